// [rtl/acs_consts.svh]
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// Register byte addresses
`define ACS_ADDR_CTRL      32'h4006_8090
`define ACS_ADDR_CFG       32'h4006_8094
`define ACS_ADDR_STAT      32'h4006_8098
`define ACS_ADDR_MASK      32'h4006_809c
`define ACS_ADDR_IRQ_STAT  32'h4006_808c
`define ACS_ADDR_IRQ_MASK  32'h4006_80f0

// Control bits
`define ACS_CTRL_START     0
`define ACS_CTRL_RESTART   1
`define ACS_CTRL_STALL     2
`define ACS_CTRL_IRQ_EN    3

// Status bits
`define ACS_STAT_CONV      0
`define ACS_STAT_STALLED   1
`define ACS_STAT_BUSY      2

// Interrupt status and mask bits
`define ACS_IRQ_CONV_DONE  0
`define ACS_IRQ_SEQ_DONE   1

// Field values
`define ACS_INTERVAL_SINGLE 8'hff
`define ACS_LAST_CHANNEL    5'h1d
`define ACS_RESET_WORD      32'h0000_0000

// Cycles of pclk per interval unit
`define ACS_TICK_CYCLES    16'h0001
`endif

// [rtl/acs_pkg.sv]
package acs_pkg;

  typedef enum logic [5:0] {
    ACS_ST_IDLE  = 6'h01,
    ACS_ST_SCAN  = 6'h02,
    ACS_ST_START = 6'h04,
    ACS_ST_CONV  = 6'h08,
    ACS_ST_GAP   = 6'h10,
    ACS_ST_DONE  = 6'h20
  } acs_fsm_type;

  typedef struct packed {
    logic        start;
    logic [4:0]  chan;
  } acs_adc_req_type;

  typedef struct packed {
    logic        irq_en;
    logic        stall;
    logic [7:0]  interval;
    logic [29:0] chan_mask;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
  } acs_regs_type;

  typedef struct packed {
    acs_fsm_type     fsm;
    acs_regs_type    regs;
    logic [4:0]      idx;
    logic [7:0]      gap_cnt;
    logic [15:0]     tick_cnt;
    logic            restart_pend;
    acs_adc_req_type adc;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } acs_core_type;

endpackage

// [rtl/acs_sequencer.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_sequencer
#(
  parameter logic [15:0] TICK_CYCLES = `ACS_TICK_CYCLES
)
(
  input  wire logic                     pclk,      // Peripheral clock
  input  wire logic                     presetn,   // Async reset, low
  input  wire logic                     psel,      // APB select
  input  wire logic                     penable,   // APB enable
  input  wire logic                     pwrite,    // APB direction
  input  wire logic [31:0]              paddr,     // APB byte address
  input  wire logic [31:0]              pwdata,    // APB write data
  output logic      [31:0]              prdata,    // APB read data
  output logic                          pready,    // APB ready
  output logic                          pslverr,   // APB error
  output acs_pkg::acs_adc_req_type      adc_req,   // Start pulse, channel
  input  wire logic                     conv_busy, // Converter busy
  output logic                          irq        // Interrupt level
);

  acs_pkg::acs_core_type q;
  acs_pkg::acs_core_type d;

  // Lowest selected channel at or above a start index
  function automatic logic [5:0] acs_next_chan(
    input logic [29:0] mask,
    input logic [4:0]  from
  );
    logic [5:0] r;
    r = 6'h00;
    for (int i = 29; i >= 0; i--)
    begin
      if (mask[i] && (i >= int'(from)))
      begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic acs_hit(
    input logic [31:0] addr,
    input logic [31:0] reg_addr
  );
    return addr == reg_addr;
  endfunction

  logic        acc_first;
  logic        wr_commit;
  logic        wr_ctrl;
  logic        wr_cfg;
  logic        wr_mask;
  logic        wr_irq_stat;
  logic        wr_irq_mask;
  logic        start_req;
  logic        restart_req;
  logic        mapped;
  logic        busy;
  logic        stalled;
  logic        conv_ev;
  logic        seq_ev;
  logic [5:0]  nxt;
  logic [1:0]  irq_clr;
  logic [31:0] rdata;

  assign busy    = q.fsm != acs_pkg::ACS_ST_IDLE;
  assign stalled = q.regs.stall &&
                   (q.fsm == acs_pkg::ACS_ST_SCAN ||
                    q.fsm == acs_pkg::ACS_ST_GAP);
  assign nxt     = acs_next_chan(q.regs.chan_mask, q.idx);

  assign mapped = acs_hit(paddr, `ACS_ADDR_CTRL) ||
                  acs_hit(paddr, `ACS_ADDR_CFG) ||
                  acs_hit(paddr, `ACS_ADDR_STAT) ||
                  acs_hit(paddr, `ACS_ADDR_MASK) ||
                  acs_hit(paddr, `ACS_ADDR_IRQ_STAT) ||
                  acs_hit(paddr, `ACS_ADDR_IRQ_MASK);

  // One wait state so that read data comes from a flip-flop
  assign acc_first   = psel && penable && !q.pready;
  assign wr_commit   = psel && penable && q.pready && pwrite &&
                       !q.pslverr;
  assign wr_ctrl     = wr_commit && acs_hit(paddr, `ACS_ADDR_CTRL);
  assign wr_cfg      = wr_commit && acs_hit(paddr, `ACS_ADDR_CFG);
  assign wr_mask     = wr_commit && acs_hit(paddr, `ACS_ADDR_MASK);
  assign wr_irq_stat = wr_commit && acs_hit(paddr, `ACS_ADDR_IRQ_STAT);
  assign wr_irq_mask = wr_commit && acs_hit(paddr, `ACS_ADDR_IRQ_MASK);
  assign start_req   = wr_ctrl && pwdata[`ACS_CTRL_START];
  assign restart_req = wr_ctrl && pwdata[`ACS_CTRL_RESTART];
  assign irq_clr     = wr_irq_stat ? pwdata[1:0] : 2'h0;

  always_comb
  begin
    rdata = `ACS_RESET_WORD;
    if (acs_hit(paddr, `ACS_ADDR_CTRL))
    begin
      // Start and restart are strobes and always read back as zero
      rdata[`ACS_CTRL_IRQ_EN] = q.regs.irq_en;
      rdata[`ACS_CTRL_STALL]  = q.regs.stall;
    end
    else if (acs_hit(paddr, `ACS_ADDR_CFG))
    begin
      rdata[7:0] = q.regs.interval;
    end
    else if (acs_hit(paddr, `ACS_ADDR_STAT))
    begin
      rdata[`ACS_STAT_BUSY]    = busy;
      rdata[`ACS_STAT_STALLED] = stalled;
      rdata[`ACS_STAT_CONV]    = conv_busy;
    end
    else if (acs_hit(paddr, `ACS_ADDR_MASK))
    begin
      rdata[29:0] = q.regs.chan_mask;
    end
    else if (acs_hit(paddr, `ACS_ADDR_IRQ_STAT))
    begin
      rdata[1:0] = q.regs.irq_stat;
    end
    else if (acs_hit(paddr, `ACS_ADDR_IRQ_MASK))
    begin
      rdata[1:0] = q.regs.irq_mask;
    end
  end

  always_comb
  begin
    d           = q;
    d.adc.start = 1'b0;
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;
    conv_ev     = 1'b0;
    seq_ev      = 1'b0;

    if (acc_first)
    begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      d.prdata  = (pwrite || !mapped) ? `ACS_RESET_WORD : rdata;
    end

    if (wr_ctrl)
    begin
      d.regs.irq_en = pwdata[`ACS_CTRL_IRQ_EN];
      d.regs.stall  = pwdata[`ACS_CTRL_STALL];
    end
    if (wr_cfg)
    begin
      d.regs.interval = pwdata[7:0];
    end
    if (wr_mask)
    begin
      d.regs.chan_mask = pwdata[29:0];
    end
    if (wr_irq_mask)
    begin
      d.regs.irq_mask = pwdata[1:0];
    end

    unique case (q.fsm)
      acs_pkg::ACS_ST_IDLE:
      begin
        if (start_req)
        begin
          d.fsm          = acs_pkg::ACS_ST_SCAN;
          d.idx          = 5'h00;
          d.restart_pend = 1'b0;
        end
      end
      acs_pkg::ACS_ST_SCAN:
      begin
        if (restart_req)
        begin
          d.idx = 5'h00;
        end
        else if (!q.regs.stall)
        begin
          if (nxt[5])
          begin
            d.idx       = nxt[4:0];
            d.adc.chan  = nxt[4:0];
            d.adc.start = 1'b1;
            d.fsm       = acs_pkg::ACS_ST_START;
          end
          else
          begin
            d.fsm = acs_pkg::ACS_ST_DONE;
          end
        end
      end
      acs_pkg::ACS_ST_START:
      begin
        // Wait for the converter to take the request; there is no limit,
        // so a converter that never raises busy leaves the sequencer here
        if (restart_req)
        begin
          d.restart_pend = 1'b1;
        end
        if (conv_busy)
        begin
          d.fsm = acs_pkg::ACS_ST_CONV;
        end
      end
      acs_pkg::ACS_ST_CONV:
      begin
        // A running conversion is never cut short; restart acts after it
        if (!conv_busy)
        begin
          conv_ev        = 1'b1;
          d.restart_pend = 1'b0;
          d.fsm          = acs_pkg::ACS_ST_SCAN;
          if (q.restart_pend || restart_req)
          begin
            d.idx = 5'h00;
          end
          else if (q.idx == `ACS_LAST_CHANNEL)
          begin
            d.fsm = acs_pkg::ACS_ST_DONE;
          end
          else
          begin
            d.idx = q.idx + 5'h01;
          end
        end
        else if (restart_req)
        begin
          d.restart_pend = 1'b1;
        end
      end
      acs_pkg::ACS_ST_DONE:
      begin
        // Interval is judged only here, at the end of a whole loop
        seq_ev     = 1'b1;
        d.idx      = 5'h00;
        d.gap_cnt  = q.regs.interval;
        d.tick_cnt = 16'h0000;
        if (q.regs.interval == `ACS_INTERVAL_SINGLE)
        begin
          d.fsm = acs_pkg::ACS_ST_IDLE;
        end
        else if (restart_req || q.regs.interval == 8'h00)
        begin
          d.fsm = acs_pkg::ACS_ST_SCAN;
        end
        else
        begin
          d.fsm = acs_pkg::ACS_ST_GAP;
        end
      end
      acs_pkg::ACS_ST_GAP:
      begin
        if (restart_req || q.gap_cnt == 8'h00)
        begin
          d.fsm = acs_pkg::ACS_ST_SCAN;
        end
        else if (!q.regs.stall)
        begin
          if (q.tick_cnt >= TICK_CYCLES - 16'h0001)
          begin
            d.tick_cnt = 16'h0000;
            d.gap_cnt  = q.gap_cnt - 8'h01;
            // Leave with the last decrement, else each gap is a cycle longer
            if (q.gap_cnt == 8'h01)
            begin
              d.fsm = acs_pkg::ACS_ST_SCAN;
            end
          end
          else
          begin
            d.tick_cnt = q.tick_cnt + 16'h0001;
          end
        end
      end
      default:
      begin
        d.fsm = acs_pkg::ACS_ST_IDLE;
      end
    endcase

    // A new event wins over a clear in the same cycle
    d.regs.irq_stat = (q.regs.irq_stat & ~irq_clr) |
                      {seq_ev, conv_ev};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q     <= '0;
      q.fsm <= acs_pkg::ACS_ST_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign adc_req = q.adc;
  assign irq     = q.regs.irq_en &&
                   |(q.regs.irq_stat & q.regs.irq_mask);

endmodule

// [bench/acs_seq_asserts.sv]
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_seq_asserts
#(
  parameter logic [15:0] TICK_CYCLES = `ACS_TICK_CYCLES
)
(
  input wire logic                     pclk,      // Clock
  input wire logic                     presetn,   // Reset, low
  input wire logic                     psel,      // Select
  input wire logic                     penable,   // Enable
  input wire logic                     pwrite,    // Direction
  input wire logic [31:0]              paddr,     // Address
  input wire logic [31:0]              pwdata,    // Write data
  input wire logic [31:0]              prdata,    // Read data
  input wire logic                     pready,    // Ready
  input wire logic                     pslverr,   // Error
  input wire acs_pkg::acs_adc_req_type adc_req,   // Start, channel
  input wire logic                     conv_busy, // Converter busy
  input wire logic                     irq        // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ok = pready && !pwrite && !pslverr;
  wire mapped = paddr inside {`ACS_ADDR_CTRL, `ACS_ADDR_CFG, `ACS_ADDR_STAT,
    `ACS_ADDR_MASK, `ACS_ADDR_IRQ_STAT, `ACS_ADDR_IRQ_MASK};
  a_ready_pulse: assert property
    (pready |=> !pready) else $error("pready held too long");
  a_one_wait: assert property
    (psel && penable && !pready |=> pready) else $error("no answer");
  a_unmapped_err: assert property
    (pready && !mapped |-> pslverr && prdata == 32'h0) else $error("bad err");
  a_conv_flag: assert property
    (rd_ok && paddr == `ACS_ADDR_STAT |-> prdata[0] == $past(conv_busy))
    else $error("conversion flag wrong");
  a_stall_busy: assert property
    (rd_ok && paddr == `ACS_ADDR_STAT |-> !prdata[1] || prdata[2])
    else $error("stalled without busy");
  a_strobe_zero: assert property
    (rd_ok && paddr == `ACS_ADDR_CTRL |-> prdata[1:0] == 2'h0)
    else $error("strobe bits read back");
  a_mask_width: assert property
    (rd_ok && paddr == `ACS_ADDR_MASK |-> prdata[31:30] == 2'h0)
    else $error("mask reserved bits set");
  a_chan_range: assert property
    (adc_req.start |-> adc_req.chan <= `ACS_LAST_CHANNEL)
    else $error("channel out of range");
  a_start_pulse: assert property
    (adc_req.start |=> !adc_req.start) else $error("start too long");
  a_no_overlap: assert property
    (adc_req.start |-> !conv_busy) else $error("start while busy");
  a_start_gap: assert property
    ($fell(conv_busy) |-> !adc_req.start ##1 !adc_req.start)
    else $error("start too soon");
  c_start: cover property (adc_req.start);
  c_error: cover property (pready && pslverr);
  c_stalled: cover property (rd_ok && paddr == `ACS_ADDR_STAT && prdata[1]);
  c_irq: cover property (irq);
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
`include "acs_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
  localparam logic [15:0] TICK = 16'h0002;
  logic                     pclk = 1'h0;
  logic                     presetn = 1'h0;
  logic                     psel = 1'h0;
  logic                     penable = 1'h0;
  logic                     pwrite = 1'h0;
  logic                     conv_busy = 1'h0;
  logic [31:0]              paddr = 32'h0;
  logic [31:0]              pwdata = 32'h0;
  logic [31:0]              prdata;
  logic [31:0]              rv;
  logic                     pready;
  logic                     pslverr;
  logic                     irq;
  logic                     err;
  acs_pkg::acs_adc_req_type adc_req;
  logic [4:0]               chans[$];
  int                       starts[$];
  int                       cyc = 0;
  int                       cnt = 0;
  int                       mismatches = 0;
  int                       checked = 0;
  always #4 pclk = ~pclk;
  acs_sequencer #(.TICK_CYCLES(TICK)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_req(adc_req), .conv_busy(conv_busy), .irq(irq));
  // Converter stand-in: busy for a few cycles after every start
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (adc_req.start === 1'b1)
    begin
      chans.push_back(adc_req.chan);
      starts.push_back(cyc);
      cnt <= 4;
      conv_busy <= 1'b1;
    end
    else if (cnt != 0)
    begin
      cnt <= cnt - 1;
      conv_busy <= (cnt != 1);
    end
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, `ACS_ADDR_STAT, 32'h0);
      if (rv[`ACS_STAT_BUSY] === 1'b0)
        break;
    end
  endtask
  task automatic t_reset();
    apb(1'b0, `ACS_ADDR_CTRL, 32'h0);
    `CHK(rv, `ACS_RESET_WORD)
    apb(1'b0, `ACS_ADDR_STAT, 32'h0);
    `CHK(rv, `ACS_RESET_WORD)
    apb(1'b0, 32'h4006_80a0, 32'h0);
    `CHK({err, rv}, 33'h1_0000_0000)
    apb(1'b1, `ACS_ADDR_MASK, 32'hffff_ffff);
    apb(1'b0, `ACS_ADDR_MASK, 32'h0);
    `CHK(rv, 32'h3fff_ffff)
    apb(1'b1, `ACS_ADDR_CFG, 32'hffff_ffff);
    apb(1'b0, `ACS_ADDR_CFG, 32'h0);
    `CHK(rv, 32'h0000_00ff)
    apb(1'b1, `ACS_ADDR_CTRL, 32'h0000_000c);
    apb(1'b0, `ACS_ADDR_CTRL, 32'h0);
    `CHK(rv, 32'h0000_000c)
    apb(1'b1, `ACS_ADDR_CTRL, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_single(input logic [31:0] ctl, input logic exp_irq);
    apb(1'b1, `ACS_ADDR_MASK, 32'h2000_0005);
    apb(1'b1, `ACS_ADDR_IRQ_MASK, 32'h0000_0002);
    chans.delete();
    apb(1'b1, `ACS_ADDR_CTRL, ctl);
    wait_idle();
    `CHK(rv[`ACS_STAT_BUSY], 1'b0)
    `CHK({chans[0], chans[1], chans[2]}, {5'h00, 5'h02, 5'h1d})
    `CHK(chans.size(), 3)
    repeat (2) @(posedge pclk);
    `CHK(irq, exp_irq)
    apb(1'b0, `ACS_ADDR_IRQ_STAT, 32'h0);
    `CHK(rv[`ACS_IRQ_SEQ_DONE], 1'b1)
    apb(1'b1, `ACS_ADDR_IRQ_STAT, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("test single done");
  endtask
  task automatic measure(input logic [7:0] iv, output int sp);
    apb(1'b1, `ACS_ADDR_MASK, 32'h0000_000a);
    apb(1'b1, `ACS_ADDR_CFG, {24'h0, iv});
    chans.delete();
    starts.delete();
    apb(1'b1, `ACS_ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 500 && starts.size() < 3; i++)
      @(posedge pclk);
    sp = starts[2] - starts[0];
    apb(1'b1, `ACS_ADDR_CFG, 32'h0000_00ff);
    wait_idle();
    `CHK(chans[$], 5'h03)
    `CHK(chans.size() % 2, 0)
  endtask
  task automatic t_interval();
    int s0;
    int s3;
    measure(8'h00, s0);
    measure(8'h03, s3);
    `CHK(s3 - s0, 3 * TICK)
    $display("test interval done");
  endtask
  task automatic t_stall();
    int n;
    apb(1'b1, `ACS_ADDR_MASK, 32'h0000_000f);
    chans.delete();
    apb(1'b1, `ACS_ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 100 && chans.size() < 1; i++)
      @(posedge pclk);
    apb(1'b1, `ACS_ADDR_CTRL, 32'h0000_0004);
    repeat (30) @(posedge pclk);
    apb(1'b0, `ACS_ADDR_STAT, 32'h0);
    `CHK(rv, 32'h0000_0006)
    n = chans.size();
    repeat (20) @(posedge pclk);
    `CHK(chans.size(), n)
    apb(1'b1, `ACS_ADDR_CTRL, 32'h0000_0002);
    wait_idle();
    `CHK(chans[n], 5'h00)
    `CHK(chans.size(), n + 4)
    $display("test stall done");
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single(32'h0000_0009, 1'b1);
    t_single(32'h0000_0001, 1'b0);
    t_interval();
    t_stall();
    stop_test();
  end
endmodule
bind acs_sequencer acs_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .adc_req(adc_req),
  .conv_busy(conv_busy), .irq(irq));
